/* logic/cxic_pkg.sv */
package cxic_pkg;
	localparam int WORD_W = 60;
	localparam int ADDR_W = 18;
	localparam int PKG_WORDS = 16;
	localparam int IDX_W = 4;
	localparam int RTC_W = 17;
	localparam int PC_COPIES = 6;
	localparam logic [IDX_W-1:0] LAST_IDX = 4'hF;

	// Package word layout
	localparam logic [IDX_W-1:0] W_PC = 4'h0;
	localparam logic [IDX_W-1:0] W_PSW = 4'h3;
	localparam logic [IDX_W-1:0] W_NEXIT = 4'h6;
	localparam logic [IDX_W-1:0] W_EEXIT = 4'h7;

	// Fixed package addresses
	localparam logic [ADDR_W-1:0] RTC_PKG_ADDR = 18'h00010;
	localparam logic [ADDR_W-1:0] DS_PKG_ADDR = 18'h00000;
	localparam int CH_SHIFT = 4;

	// Status word bits
	localparam int PS_MONITOR = 0;
	localparam int PS_STEP = 1;
	localparam int PS_PRIV = 2;
	localparam int PS_OVF_MODE = 3;
	localparam int PS_UND_MODE = 4;
	localparam int PS_IND_MODE = 5;
	localparam int PS_OVF = 6;
	localparam int PS_UND = 7;
	localparam int PS_IND = 8;
	localparam int PS_RANGE = 9;
	localparam int PS_HWFAIL = 10;
	localparam int PS_W = 18;

	// APB register byte offsets
	localparam logic [7:0] OFS_BIAS = 8'h00;
	localparam logic [7:0] OFS_CHREQ = 8'h04;
	localparam logic [7:0] OFS_RTC = 8'h08;
	localparam logic [7:0] OFS_PSW = 8'h0C;
	localparam logic [7:0] OFS_PC = 8'h10;
	localparam logic [7:0] OFS_IOBASE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	typedef enum logic [3:0] {
		X_IDLE = 4'b0001,
		X_READ = 4'b0010,
		X_WRITE = 4'b0100,
		X_DONE = 4'b1000
	} cxic_xstate_t;

	typedef enum logic [2:0] {
		C_NONE = 3'h0,
		C_ERROR = 3'h1,
		C_STEP = 3'h2,
		C_EXIT = 3'h3,
		C_IO = 3'h4,
		C_RTC = 3'h5
	} cxic_cause_t;

	typedef struct packed {
		logic valid;
		cxic_cause_t cause;
		logic [ADDR_W-1:0] addr;
	} cxic_xreq_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} cxic_cm_t;
endpackage : cxic_pkg

/* logic/cxic_top.sv */
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
// Function
// - Error-exit opcode ends the interval with an exchange to the error exit pointer.
// - Overflow, underflow, indefinite either continue or error-exit per status word mode bits.
// - Hardware failure and out-of-field addressing always force an error exit.
// - Status word loads from incoming package and is stored back on exit.
// - Buffer threshold from the io_multiplexer raises an interrupt request.
// - Peripheral record pulse and exchange request each raise an interrupt request.
// - Accepted I/O request starts an exchange to the interrupt package.
// - Clock-period counter advances by one every clock cycle.
// - Counter is 17 bits and readable as channel zero status.
// - Counter carry sets real-time flag held as the eighteenth bit.
// - Real-time flag requests exchange to octal 20 plus buffer bias.
// - Step mode exchanges to error exit pointer after each instruction word.
// - Monitor flag blocks interrupt requests; pending ones served in order when clear.
// - Channel request stays pending and reinterrupts a non-monitor interrupt program.
// - Deadstart clears channel requests leaving channel zero, exchanging on release.
// - Deadstart exchange swaps with package at 0 to 17 octal plus bias.
// - Deadstart stored status word has monitor cleared and program range set.
// - Six program counter copies always hold the same value.
// - Latch setting with error opcode blocks range flag; counter already advanced.
// - Each exchange swaps sixteen package words with CPU registers from first address.
// - Privileged flag clear makes exchange exit use the normal exit pointer.
module cxic_top import cxic_pkg::*; #(
	parameter int NCH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Issue logic, same clock
	input wire logic err_opcode,
	input wire logic exit_opcode,
	input wire logic [ADDR_W-1:0] exit_bjk,
	input wire logic arith_ovf,
	input wire logic arith_und,
	input wire logic arith_ind,
	input wire logic hw_fail,
	input wire logic range_err,
	input wire logic word_done,
	output logic exch_busy,
	output logic [PS_W-1:0] program_status_word,
	output logic [PC_COPIES-1:0][ADDR_W-1:0] pc_copies,
	output logic [RTC_W-1:0] chan0_status,
	// From io_multiplexer and peripheral_processor pins
	input wire logic [NCH-1:0] buf_threshold,
	input wire logic [NCH-1:0] record_pulse,
	input wire logic pp_exchange_req,
	// central_memory port
	output cxic_cm_t cm_out,
	input wire logic cm_ack,
	input wire logic [WORD_W-1:0] cm_rdata
);
	localparam int CH_W = $clog2(NCH);

	logic [NCH-1:0] chreq;
	logic [ADDR_W-1:0] bias;
	logic [ADDR_W-1:0] io_base;
	logic [RTC_W:0] rtc;
	logic [PS_W-1:0] psw;
	logic [ADDR_W-1:0] pc_copy [PC_COPIES];
	logic [WORD_W-1:0] regs [PKG_WORDS];
	logic [WORD_W-1:0] hold;
	logic [IDX_W-1:0] idx;
	logic [ADDR_W-1:0] base;
	cxic_xstate_t xstate;
	cxic_cause_t cause_last;
	logic ds_pend;
	logic ds_exch;
	logic pending_interrupt_latch;
	logic err_pend;
	logic step_pend;
	logic exit_pend;
	logic [ADDR_W-1:0] exit_addr;
	// Pin synchronisers: three stages, change counts when stages 2 and 3 agree
	logic [2*NCH:0] sync1, sync2, sync3, stable, stable_d;
	logic [2*NCH:0] pin_rise;
	cxic_xreq_t next_req;
	logic io_open;
	logic err_event;
	logic rif_set;
	logic apb_wr;
	logic apb_rd;
	logic [NCH-1:0] ch_clear;
	logic rtc_clear;

	function automatic logic [CH_W-1:0] lowest_ch(input logic [NCH-1:0] v);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = CH_W'(i);
			end
		end
		return r;
	endfunction : lowest_ch

	function automatic logic [ADDR_W-1:0] field(input logic [WORD_W-1:0] w);
		return w[ADDR_W-1:0];
	endfunction : field

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			stable <= '0;
			stable_d <= '0;
		end else begin
			sync1 <= {pp_exchange_req, record_pulse, buf_threshold};
			sync2 <= sync1;
			sync3 <= sync2;
			stable <= (stable & (sync2 ^ sync3)) | (sync2 & sync3);
			stable_d <= stable;
		end
	end
	assign pin_rise = stable & ~stable_d;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign exch_busy = (xstate != X_IDLE);
	assign io_open = !psw[PS_MONITOR] && !exch_busy;
	// Latch sets when a gated I/O or real-time request is accepted
	assign rif_set = io_open && !pending_interrupt_latch && ((|chreq) || rtc[RTC_W]);
	// Error opcode coinciding with the latch setting is swallowed
	assign err_event = !exch_busy && ((err_opcode && !rif_set) || hw_fail || range_err
		|| (arith_ovf && psw[PS_OVF_MODE]) || (arith_und && psw[PS_UND_MODE])
		|| (arith_ind && psw[PS_IND_MODE]));

	// Channel request register
	always_comb begin
		ch_clear = '0;
		if (apb_wr && paddr == OFS_CHREQ) begin
			ch_clear = pwdata[NCH-1:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chreq <= NCH'(1);
		end else begin
			// Set wins over clear; cleared only by software so it repeats
			chreq <= (chreq & ~ch_clear) | pin_rise[NCH-1:0] | pin_rise[2*NCH-1:NCH]
				| {{(NCH-1){1'b0}}, pin_rise[2*NCH]};
		end
	end

	// Clock-period counter with real-time flag as its top bit
	assign rtc_clear = (apb_wr && paddr == OFS_RTC && pwdata[RTC_W])
		|| (xstate == X_DONE && cause_last == C_RTC);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rtc <= '0;
		end else begin
			rtc[RTC_W-1:0] <= rtc[RTC_W-1:0] + RTC_W'(1);
			rtc[RTC_W] <= (&rtc[RTC_W-1:0]) || (rtc[RTC_W] && !rtc_clear);
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan0_status <= '0;
		end else begin
			chan0_status <= rtc[RTC_W-1:0];
		end
	end

	// Pending exchange sources
	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_pend <= 1'b0;
			step_pend <= 1'b0;
			exit_pend <= 1'b0;
			exit_addr <= '0;
			pending_interrupt_latch <= 1'b0;
		end else if (xstate == X_IDLE && next_req.valid) begin
			err_pend <= 1'b0;
			step_pend <= 1'b0;
			exit_pend <= 1'b0;
			pending_interrupt_latch <= 1'b0;
		end else begin
			err_pend <= err_pend || err_event;
			step_pend <= step_pend || (word_done && psw[PS_STEP] && !exch_busy);
			if (exit_opcode && !exch_busy) begin
				exit_pend <= 1'b1;
				exit_addr <= psw[PS_PRIV] ? exit_bjk : field(regs[W_NEXIT]);
			end
			pending_interrupt_latch <= pending_interrupt_latch || rif_set;
		end
	end

	// Fixed-priority selection of the next package
	always_comb begin
		next_req = '{valid: 1'b0, cause: C_NONE, addr: '0};
		if (err_pend) begin
			next_req = '{valid: 1'b1, cause: C_ERROR, addr: field(regs[W_EEXIT])};
		end else if (step_pend) begin
			next_req = '{valid: 1'b1, cause: C_STEP, addr: field(regs[W_EEXIT])};
		end else if (exit_pend) begin
			next_req = '{valid: 1'b1, cause: C_EXIT, addr: exit_addr};
		end else if (pending_interrupt_latch && |chreq) begin
			next_req = '{valid: 1'b1, cause: C_IO,
				addr: ADDR_W'(io_base + (ADDR_W'(lowest_ch(chreq)) << CH_SHIFT) + bias)};
		end else if (pending_interrupt_latch && rtc[RTC_W]) begin
			next_req = '{valid: 1'b1, cause: C_RTC, addr: ADDR_W'(RTC_PKG_ADDR + bias)};
		end
	end

	// Exchange sequencer: read package word, write CPU word back, load
	always_ff @(posedge core_clk) begin
		if (rst) begin
			xstate <= X_IDLE;
			idx <= '0;
			base <= '0;
			hold <= '0;
			cause_last <= C_NONE;
			ds_exch <= 1'b0;
		end else begin
			unique case (xstate)
				X_IDLE: begin
					if (next_req.valid) begin
						xstate <= X_READ;
						idx <= '0;
						cause_last <= next_req.cause;
						ds_exch <= ds_pend && next_req.cause == C_IO && lowest_ch(chreq) == '0;
						base <= (ds_pend && next_req.cause == C_IO) ? ADDR_W'(DS_PKG_ADDR + bias)
							: next_req.addr;
					end
				end
				X_READ: begin
					if (cm_ack) begin
						hold <= cm_rdata;
						xstate <= X_WRITE;
					end
				end
				X_WRITE: begin
					if (cm_ack) begin
						idx <= idx + IDX_W'(1);
						xstate <= (idx == LAST_IDX) ? X_DONE : X_READ;
					end
				end
				X_DONE: begin
					xstate <= X_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ds_pend <= 1'b1;
		end else if (xstate == X_DONE && ds_exch) begin
			ds_pend <= 1'b0;
		end
	end

	// Outgoing word for the central_memory write of the current index
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cm_out <= '0;
		end else begin
			cm_out.req <= (xstate == X_READ && !cm_ack) || (xstate == X_WRITE && !(cm_ack && idx == LAST_IDX))
				|| (xstate == X_READ && cm_ack) || (xstate == X_IDLE && next_req.valid)
				|| (xstate == X_WRITE && cm_ack && idx != LAST_IDX);
			if (xstate == X_IDLE) begin
				cm_out.we <= 1'b0;
				cm_out.addr <= (ds_pend && next_req.cause == C_IO) ? ADDR_W'(DS_PKG_ADDR + bias) : next_req.addr;
			end else if (xstate == X_READ && cm_ack) begin
				cm_out.we <= 1'b1;
				if (idx == W_PC) begin
					cm_out.wdata <= WORD_W'(pc_copy[0]);
				end else if (idx == W_PSW) begin
					cm_out.wdata <= ds_exch
						? WORD_W'((psw & ~(PS_W'(1) << PS_MONITOR)) | (PS_W'(1) << PS_RANGE))
						: WORD_W'(psw);
				end else begin
					cm_out.wdata <= regs[idx];
				end
			end else if (xstate == X_WRITE && cm_ack) begin
				cm_out.we <= 1'b0;
				cm_out.addr <= ADDR_W'(base + ADDR_W'(idx) + ADDR_W'(1));
			end
		end
	end

	// CPU side registers of the package
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < PKG_WORDS; i++) begin
				regs[i] <= '0;
			end
		end else if (xstate == X_WRITE && cm_ack) begin
			regs[idx] <= hold;
		end
	end

	// Status word: loaded from the package, error flags set during the interval
	always_ff @(posedge core_clk) begin
		if (rst) begin
			psw <= '0;
		end else if (xstate == X_WRITE && cm_ack && idx == W_PSW) begin
			psw <= hold[PS_W-1:0];
		end else if (!exch_busy) begin
			psw[PS_OVF] <= psw[PS_OVF] || arith_ovf;
			psw[PS_UND] <= psw[PS_UND] || arith_und;
			psw[PS_IND] <= psw[PS_IND] || arith_ind;
			psw[PS_HWFAIL] <= psw[PS_HWFAIL] || hw_fail;
			psw[PS_RANGE] <= psw[PS_RANGE] || range_err || (err_opcode && !rif_set);
		end
	end
	assign program_status_word = psw;

	// Program counter copies updated together
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < PC_COPIES; i++) begin
				pc_copy[i] <= '0;
			end
		end else begin
			for (int i = 0; i < PC_COPIES; i++) begin
				if (xstate == X_WRITE && cm_ack && idx == W_PC) begin
					pc_copy[i] <= field(hold);
				end else if (!exch_busy && (word_done || (err_opcode && rif_set))) begin
					pc_copy[i] <= pc_copy[i] + ADDR_W'(1);
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < PC_COPIES; i++) begin
			pc_copies[i] = pc_copy[i];
		end
	end

	// Software registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bias <= '0;
			io_base <= '0;
		end else if (apb_wr) begin
			if (paddr == OFS_BIAS) begin
				bias <= pwdata[ADDR_W-1:0];
			end
			if (paddr == OFS_IOBASE) begin
				io_base <= pwdata[ADDR_W-1:0];
			end
		end
	end

	always_comb begin
		prdata = '0;
		pslverr = 1'b0;
		if (psel && penable) begin
			unique case (paddr)
				OFS_BIAS: prdata = 32'(bias);
				OFS_CHREQ: prdata = 32'(chreq);
				OFS_RTC: prdata = 32'(rtc);
				OFS_PSW: prdata = 32'(psw);
				OFS_PC: prdata = 32'(pc_copy[0]);
				OFS_IOBASE: prdata = 32'(io_base);
				OFS_STATUS: prdata = 32'({cause_last, ds_pend, pending_interrupt_latch, exch_busy});
				default: pslverr = 1'b1;
			endcase
		end
		if (!apb_rd) begin
			prdata = '0;
		end
	end
endmodule : cxic_top

/* tb/cxic_top_sva.sv */
`timescale 1ns/10ps
module cxic_top_sva import cxic_pkg::*; #(
	parameter int NCH = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic err_opcode,
	input wire logic exch_busy,
	input wire logic [PC_COPIES-1:0][ADDR_W-1:0] pc_copies,
	input wire logic [RTC_W-1:0] chan0_status,
	input wire cxic_cm_t cm_out,
	input wire logic cm_ack
);
	logic [5:0] acks;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Accesses taken in the running exchange
	always_ff @(posedge core_clk) begin
		if (rst || !exch_busy)
			acks <= 6'h00;
		else if (cm_out.req && cm_ack)
			acks <= acks + 6'h01;
	end
	sequence s_read_ack;
		cm_out.req && cm_ack && !cm_out.we;
	endsequence
	sequence s_write_ack;
		cm_out.req && cm_ack && cm_out.we && acks < 6'h1F;
	endsequence
	sequence s_next_read;
		cm_out.req && !cm_out.we && cm_out.addr == $past(cm_out.addr) + 18'h00001;
	endsequence
	a_count_step: assert property (!$past(rst) && !$past(rst, 2) |-> chan0_status == $past(chan0_status) + 17'h00001)
		else $error("count did not advance by one");
	a_pc_match: assert property (pc_copies[5:1] == {5{pc_copies[0]}})
		else $error("program counter copies differ");
	a_err_exit: assert property (err_opcode && !exch_busy |-> ##[1:3] exch_busy)
		else $error("error exit did not start");
	a_req_hold: assert property (cm_out.req && !cm_ack |=> $stable(cm_out))
		else $error("memory request changed before acknowledge");
	a_word_pair: assert property (s_read_ack |=> cm_out.req && cm_out.we && $stable(cm_out.addr))
		else $error("word read not followed by its write");
	a_word_next: assert property (s_write_ack |=> s_next_read)
		else $error("next package word not read");
	a_word_count: assert property ($fell(exch_busy) |-> acks == 6'h20)
		else $error("exchange did not move sixteen words both ways");
	a_ds_start: assert property ($fell(rst) |-> ##[1:4] (cm_out.req && cm_out.addr == DS_PKG_ADDR))
		else $error("deadstart exchange missing");
	a_idle_quiet: assert property (!exch_busy |-> !cm_out.req)
		else $error("memory request while idle");
endmodule : cxic_top_sva

bind cxic_top cxic_top_sva #(.NCH(NCH)) u_cxic_top_sva (.core_clk(core_clk), .rst(rst), .err_opcode(err_opcode),
	.exch_busy(exch_busy), .pc_copies(pc_copies), .chan0_status(chan0_status), .cm_out(cm_out), .cm_ack(cm_ack));

/* tb/cxic_cm_model.sv */
`timescale 1ns/10ps
module cxic_cm_model import cxic_pkg::*; (
	input wire logic core_clk,
	input wire logic slow,
	input wire cxic_cm_t cm_out,
	output logic cm_ack,
	output logic [WORD_W-1:0] cm_rdata
);
	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [1:0] wait_cnt;
	initial begin
		cm_ack = 1'b0;
		cm_rdata = '0;
		wait_cnt = 2'h0;
		for (int i = 0; i < (1 << ADDR_W); i++)
			mem[i] = '0;
	end
	// Each package word read, then overwritten; data toggles when not valid
	always @(posedge core_clk) begin
		if (cm_ack || !cm_out.req) begin
			cm_ack <= 1'b0;
			wait_cnt <= 2'h0;
			cm_rdata <= ~cm_rdata;
		end else if (!slow || wait_cnt == 2'h3) begin
			cm_ack <= 1'b1;
			cm_rdata <= mem[cm_out.addr];
			if (cm_out.we)
				mem[cm_out.addr] <= cm_out.wdata;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
			cm_rdata <= ~cm_rdata;
		end
	end
endmodule : cxic_cm_model

/* tb/test_cpu_exchange_interrupt_control.sv */
`timescale 1ns/10ps
module test_cpu_exchange_interrupt_control import cxic_pkg::*;;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, exch_busy, cm_ack, slow, pp_req, err;
	logic [7:0] paddr, iss, thr, rec;
	logic [31:0] pwdata, prdata, rd, t0;
	logic [ADDR_W-1:0] bjk, pc_exp;
	logic [PS_W-1:0] psw;
	logic [PC_COPIES-1:0][ADDR_W-1:0] pcs;
	logic [RTC_W-1:0] c0s;
	logic [WORD_W-1:0] rdat;
	logic req_q;
	cxic_cm_t cm_out;
	logic [ADDR_W-1:0] starts[$];
	int mismatches, n_tests, exp_chreq;
	cxic_top #(.NCH(8)) u_cxic_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_opcode(iss[0]),
		.exit_opcode(iss[1]), .exit_bjk(bjk), .arith_ovf(iss[2]), .arith_und(iss[3]), .arith_ind(iss[4]),
		.hw_fail(iss[5]), .range_err(iss[6]), .word_done(iss[7]), .exch_busy(exch_busy), .program_status_word(psw),
		.pc_copies(pcs), .chan0_status(c0s), .buf_threshold(thr), .record_pulse(rec), .pp_exchange_req(pp_req),
		.cm_out(cm_out), .cm_ack(cm_ack), .cm_rdata(rdat));
	cxic_cm_model u_cxic_cm_model (.core_clk(core_clk), .slow(slow), .cm_out(cm_out), .cm_ack(cm_ack), .cm_rdata(rdat));
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize();
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Start address of each exchange, in order
	always @(negedge core_clk) begin
		req_q <= cm_out.req;
		if (cm_out.req === 1'b1 && req_q !== 1'b1)
			starts.push_back(cm_out.addr);
	end
	task automatic exch(input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		while (starts.size() == 0 && n < 60) begin
			n++;
			@(negedge core_clk);
		end
		chk("package address", a, starts.size() ? starts.pop_front() : 'x);
		while (exch_busy !== 1'b0 && n < 600) begin
			n++;
			@(negedge core_clk);
		end
		chk("exchange done", 1'b0, exch_busy);
	endtask : exch
	task automatic quiet(input int c);
		repeat (c) begin
			@(negedge core_clk);
			chk("busy", 1'b0, exch_busy);
		end
	endtask : quiet
	task automatic pulse(input int i);
		@(posedge core_clk);
		iss[i] <= 1'b1;
		@(posedge core_clk);
		iss <= 8'h00;
	endtask : pulse
	task automatic pkg(input logic [ADDR_W-1:0] b, input logic [PS_W-1:0] ps, input logic [ADDR_W-1:0] nxt,
		input logic [ADDR_W-1:0] eep);
		for (int k = 0; k < PKG_WORDS; k++)
			u_cxic_cm_model.mem[b + k] = WORD_W'({$urandom, $urandom});
		pc_exp = ADDR_W'($urandom);
		u_cxic_cm_model.mem[b + W_PC] = WORD_W'(pc_exp);
		u_cxic_cm_model.mem[b + W_PSW] = WORD_W'(ps);
		u_cxic_cm_model.mem[b + W_NEXIT] = WORD_W'(nxt);
		u_cxic_cm_model.mem[b + W_EEXIT] = WORD_W'(eep);
	endtask : pkg
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		summarize();
	end
	initial begin
		void'($urandom(4141));
		{rst, psel, penable, pwrite, slow, pp_req, err} = 7'h40;
		paddr = 8'h00;
		pwdata = 32'h0;
		iss = 8'h00;
		thr = 8'h00;
		rec = 8'h00;
		bjk = 18'h00000;
		mismatches = 0;
		n_tests = 0;
		@(posedge core_clk);
		pkg(DS_PKG_ADDR, 18'h00001, 18'h00000, 18'h00100);
		repeat (9) @(posedge core_clk);
		rst <= 1'b0;
		exch(DS_PKG_ADDR);
		chk("stored status word", 18'h00200, u_cxic_cm_model.mem[W_PSW][PS_W-1:0]);
		chk("status word", 18'h00001, psw);
		chk("program counter", pc_exp, pcs[0]);
		exp_chreq = 1;
		apb(1'b0, OFS_CHREQ, 32'h0);
		chk("channel requests", exp_chreq, rd);
		apb(1'b1, OFS_CHREQ, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 1'b1, err);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, OFS_IOBASE, 32'h400);
		apb(1'b1, OFS_BIAS, 32'h40);
		apb(1'b0, OFS_BIAS, 32'h0);
		chk("bias", 32'h40, rd);
		apb(1'b0, OFS_RTC, 32'h0);
		t0 = rd;
		apb(1'b0, OFS_RTC, 32'h0);
		chk("count step", 32'h3, rd - t0);
		@(posedge core_clk);
		thr <= 8'h04;
		rec <= 8'h20;
		pp_req <= 1'b1;
		quiet(12);
		exp_chreq = 32'h25;
		apb(1'b0, OFS_CHREQ, 32'h0);
		chk("channel requests", exp_chreq, rd);
		apb(1'b1, OFS_CHREQ, 32'h21);
		pkg(18'h00460, 18'h00008, 18'h00000, 18'h00200);
		pkg(18'h00200, 18'h00003, 18'h00000, 18'h00300);
		pkg(18'h00300, 18'h00001, 18'h00500, 18'h00000);
		pkg(18'h00500, 18'h00001, 18'h00000, 18'h00100);
		pkg(18'h00100, 18'h00008, 18'h00000, 18'h00200);
		pulse(2);
		quiet(8);
		pulse(5);
		exch(18'h00100);
		exch(18'h00460);
		fork
			begin
				wait (exch_busy === 1'b1);
				apb(1'b1, OFS_CHREQ, 32'h4);
			end
			exch(18'h00460);
		join
		exp_chreq = 0;
		apb(1'b0, OFS_CHREQ, 32'h0);
		chk("channel requests", exp_chreq, rd);
		pulse(2);
		exch(18'h00200);
		pulse(7);
		exch(18'h00300);
		slow = 1'b1;
		bjk <= ADDR_W'($urandom);
		pulse(1);
		exch(18'h00500);
		slow = 1'b0;
		pulse(0);
		exch(18'h00100);
		summarize();
	end
endmodule : test_cpu_exchange_interrupt_control
